// ---- sim/amd_drive_model.sv ----
module amd_drive_model (
    input  wire amd_pkg::amd_ctl_t          disk_ctl,
    input  wire logic                       arm,
    input  wire logic [amd_pkg::LEN_W-1:0]  limit,
    input  wire logic [amd_pkg::DATA_W-1:0] base,
    output logic                            disk_dma_request,
    output logic [amd_pkg::DATA_W-1:0]      disk_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import amd_pkg::*;
    logic [LEN_W-1:0] cnt = LEN_ZERO;
    wire [DATA_W-1:0] word = base + cnt - LEN_ONE;
    initial disk_dma_request = 1'b0;
    always @(posedge arm) begin
        cnt = LEN_ZERO;
        disk_dma_request = (limit != LEN_ZERO);
    end
    // drop at the last strobe, well inside one word cycle
    always @(negedge disk_ctl.read_strobe_n or negedge disk_ctl.write_strobe_n) begin
        cnt = cnt + LEN_ONE;
        if (cnt >= limit) disk_dma_request = 1'b0;
    end
    // released bus shows the inverse, never a stale word
    assign disk_data_in = disk_ctl.read_strobe_n ? ~word : word;
endmodule : amd_drive_model

// ---- sim/amd_mdma_assertions.sv ----
module amd_mdma_assertions (
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire amd_pkg::amd_timing_t multiword_timing_setting,
    input wire amd_pkg::amd_ctl_t    disk_ctl,
    input wire logic                 disk_data_oe,
    input wire logic                 alternate_disk_data_bus_oe,
    input wire logic                 rd_valid
);
    import amd_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire amd_timing_t tm  = multiword_timing_setting;
    wire              rl  = !disk_ctl.read_strobe_n;
    wire              wl  = !disk_ctl.write_strobe_n;
    wire              stb = rl | wl;
    wire              ack = !disk_ctl.dma_ack_n;
    wire              oe  = disk_data_oe | alternate_disk_data_bus_oe;
    logic [8:0]       lo_r, hi_r, ack_r;
    logic             seen_r, wl_r;
    // ------------------------------------------------------------
    // phase counters
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {lo_r, hi_r, ack_r, seen_r, wl_r} <= '0;
        end else begin
            lo_r   <= stb ? lo_r + 9'h001 : 9'h000;
            hi_r   <= stb ? 9'h000 : hi_r + 9'h001;
            ack_r  <= ack ? ack_r + 9'h001 : 9'h000;
            seen_r <= ack && (seen_r || stb);
            wl_r   <= ack && (stb ? wl : wl_r);
        end
    end
    a_strobe_width: assert property ($fell(stb) |-> lo_r == 9'(tm.strobe_active_count))
        else $error("strobe width wrong");
    a_read_gap: assert property ($rose(rl) && seen_r |-> hi_r >= 9'(tm.read_negation_count)
        && hi_r >= 9'(tm.strobe_recovery_count)) else $error("read gap short");
    a_write_gap: assert property ($rose(wl) && seen_r |-> hi_r >= 9'(tm.write_negation_count)
        && hi_r >= 9'(tm.strobe_recovery_count)) else $error("write gap short");
    a_ack_setup: assert property ($rose(stb) && !seen_r |-> ack
        && ack_r >= 9'(tm.select_setup_count)) else $error("ack setup short");
    a_ack_hold: assert property ($fell(ack) |-> hi_r == 9'(tm.strobe_recovery_count)
        + 9'(tm.end_of_cycle_extension)) else $error("ack hold wrong");
    a_cs_idle: assert property (disk_ctl.cs_low_n && disk_ctl.cs_high_n)
        else $error("chip select moved");
    a_write_drive: assert property (wl |-> oe
        && !(disk_data_oe && alternate_disk_data_bus_oe)) else $error("write data not driven");
    a_write_hold: assert property (!stb && wl_r && hi_r < 9'(tm.strobe_recovery_count) |-> oe)
        else $error("write data dropped early");
    a_read_capture: assert property (rd_valid |-> $fell(rl))
        else $error("read capture misplaced");
    cover property (rd_valid);
    cover property ($fell(wl));
    cover property (alternate_disk_data_bus_oe);
endmodule : amd_mdma_assertions

bind amd_mdma amd_mdma_assertions u_amd_mdma_assertions (.mclk, .sys_rst,
    .multiword_timing_setting, .disk_ctl, .disk_data_oe, .alternate_disk_data_bus_oe, .rd_valid);

// ---- sim/amd_mdma_tb.sv ----
module amd_mdma_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amd_pkg::*;
    logic              mclk, sys_rst, cmd_start, busy, word_req, rd_valid, req, arm, d_oe, a_oe;
    amd_timing_t       tm;
    amd_cmd_t          cmd;
    amd_ctl_t          ctl;
    logic [DATA_W-1:0] wr_data, rd_data, d_out, a_out, mdl_d, base;
    logic [LEN_W-1:0]  limit;
    logic [DATA_W-1:0] exp_q[$];
    int                errors, checks_done, pushed, seed = 13992;
    wire [DATA_W-1:0]  din_p = cmd.use_alternate ? ~mdl_d : mdl_d;
    wire [DATA_W-1:0]  din_a = cmd.use_alternate ? mdl_d : ~mdl_d;
    wire [DATA_W-1:0]  wr_bus = cmd.use_alternate ? (a_oe ? a_out : 'x) : (d_oe ? d_out : 'x);
    logic              wstb_prev_r = 1'b1;
    amd_mdma u_amd_mdma (.mclk, .sys_rst, .multiword_timing_setting(tm), .cmd, .cmd_start,
        .busy, .word_req, .wr_data, .rd_data, .rd_valid, .disk_dma_request(req),
        .disk_ctl(ctl), .disk_data_out(d_out), .disk_data_oe(d_oe),
        .disk_data_in(din_p), .alternate_disk_data_bus_out(a_out),
        .alternate_disk_data_bus_oe(a_oe), .alternate_disk_data_bus_in(din_a));
    amd_drive_model u_amd_drive_model (.disk_ctl(ctl), .arm, .limit, .base,
        .disk_dma_request(req), .disk_data_in(mdl_d));
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk
    task automatic take(input logic [DATA_W-1:0] got);
        int n;
        logic [DATA_W-1:0] e;
        n = exp_q.size();
        if (n != 0) e = exp_q.pop_front();
        chk(n != 0 && got === e, "data word mismatch");
    endtask : take
    task automatic close_out();
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    function automatic int rnd4();
        return {$random(seed)} % 4;
    endfunction : rnd4
    // outputs settle off the edge; strobe history starts high, so no false edge
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) take(rd_data);
        if (ctl.write_strobe_n === 1'b1 && wstb_prev_r === 1'b0) take(wr_bus);
        wstb_prev_r = ctl.write_strobe_n;
    end
    always @(negedge mclk) if (word_req === 1'b1) begin
        exp_q.push_back(wr_data);
        pushed++;
        wr_data = 16'($random(seed));
    end
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    task automatic run(input int t);
        int w, k;
        w = 2 + rnd4();
        tm = {8'(3 + rnd4()), 8'(1 + rnd4()), 8'(1 + rnd4()), 8'(1 + rnd4()),
              8'(1 + rnd4()), 8'(1 + rnd4())};
        base = 16'($random(seed));
        wr_data = 16'($random(seed));
        limit = 16'((t > 5) ? w - 1 : w);
        pushed = 0;
        if (!t[0]) for (int i = 0; i < limit; i++) exp_q.push_back(base + 16'(i));
        arm = 1'b1;
        @(negedge mclk) arm = 1'b0;
        repeat (3) @(negedge mclk);
        cmd = {t[0], t[1], 16'(w)};
        cmd_start = 1'b1;
        @(negedge mclk) cmd_start = 1'b0;
        for (k = 0; k < 2000 && (busy !== 1'b0 || k < 2); k++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        chk(k < 2000 && exp_q.size() == 0, "burst length wrong");
        if (t[0]) chk(pushed == limit, "write word count wrong");
    endtask : run
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {sys_rst, cmd_start, arm} = 3'b100;
        {limit, base, wr_data, cmd} = '0;
        tm = {6{8'h03}};
        repeat (8) @(posedge mclk);
        @(negedge mclk) sys_rst = 1'b0;
        cmd = {2'b00, 16'h0002};
        cmd_start = 1'b1;
        repeat (6) @(negedge mclk);
        chk(busy === 1'b0 && ctl === CTL_IDLE, "start taken without request");
        cmd_start = 1'b0;
        for (int t = 0; t < 8; t++) run(t);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out();
    end
endmodule : amd_mdma_tb

// ---- src/amd_cnt.sv ----
// ------------------------------------------------------------
// phase down-counter: load, then holds expired high once it counts down to one
// ------------------------------------------------------------
module amd_cnt (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     load,
    input  wire logic [amd_pkg::CNT_W-1:0] value,
    output logic                          expired
);
    import amd_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    assign cnt_nxt = load ? value : ((cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - CNT_ONE);
    // a zero setting is treated as one cycle
    assign expired = (cnt_r <= CNT_ONE);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : amd_cnt

// ---- src/amd_mdma.sv ----
// Notes on behaviour
// - strobe held active exactly strobe-active cycles; word cycle active plus the longer of recovery and negation
// - read strobe negated at least read-negation and recovery cycles between read words
// - write strobe negated at least write-negation and recovery cycles between write words
// - acknowledge asserted setup cycles before first strobe of a burst
// - acknowledge held recovery plus end-of-cycle cycles after final strobe
// - chip selects never asserted; both held high throughout
// - write data presented for whole strobe-active time before strobe negates
// - write data kept driven recovery cycles after write strobe negates
// - data bus carried on primary or alternate pins, same timing
module amd_mdma (
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    input  wire amd_pkg::amd_timing_t      multiword_timing_setting,
    input  wire amd_pkg::amd_cmd_t         cmd,
    input  wire logic                      cmd_start,
    output logic                           busy,
    output logic                           word_req,
    input  wire logic [amd_pkg::DATA_W-1:0] wr_data,
    output logic [amd_pkg::DATA_W-1:0]     rd_data,
    output logic                           rd_valid,
    input  wire logic                      disk_dma_request,
    output amd_pkg::amd_ctl_t              disk_ctl,
    output logic [amd_pkg::DATA_W-1:0]     disk_data_out,
    output logic                           disk_data_oe,
    input  wire logic [amd_pkg::DATA_W-1:0] disk_data_in,
    output logic [amd_pkg::DATA_W-1:0]     alternate_disk_data_bus_out,
    output logic                           alternate_disk_data_bus_oe,
    input  wire logic [amd_pkg::DATA_W-1:0] alternate_disk_data_bus_in
);
    import amd_pkg::*;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOV, ST_NEG, ST_EOC
    } amd_state_t;

    // write data stands from strobe assertion through recovery
    function automatic logic in_data_phase(input amd_state_t s);
        return (s == ST_ACTIVE) || (s == ST_RECOV);
    endfunction : in_data_phase

    amd_state_t        state_r;
    amd_state_t        state_nxt;
    amd_cmd_t          cmd_r;
    logic [LEN_W-1:0]  left_r;
    logic [CNT_W-1:0]  load_val;
    logic              load;
    logic              expired;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic              dreq_s1_r;
    logic              dreq_s2_r;
    logic [DATA_W-1:0] din_s1_r;
    logic [DATA_W-1:0] din_s2_r;
    logic [DATA_W-1:0] din_sel;

    // data pins routed by command; timing path is shared
    assign din_sel = cmd_r.use_alternate ? alternate_disk_data_bus_in : disk_data_in;

    // request and data move freely against mclk; two stages before use
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dreq_s1_r <= 1'b0;
            dreq_s2_r <= 1'b0;
            din_s1_r  <= DATA_RST;
            din_s2_r  <= DATA_RST;
        end else begin
            dreq_s1_r <= disk_dma_request;
            dreq_s2_r <= dreq_s1_r;
            din_s1_r  <= din_sel;
            din_s2_r  <= din_s1_r;
        end
    end

    amd_cnt u_amd_cnt (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .load    (load),
        .value   (load_val),
        .expired (expired)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    amd_timing_t t;
    logic        more;
    logic        start_ok;
    logic [CNT_W-1:0] neg_cnt;
    logic             neg_long;
    logic             drive_win;

    assign t        = multiword_timing_setting;
    assign start_ok = cmd_start && dreq_s2_r && (cmd.word_count != LEN_ZERO);
    // another word only while request stands and count remains
    assign more     = dreq_s2_r && (left_r != LEN_ZERO);
    assign neg_cnt  = cmd_r.dir_write ? t.write_negation_count : t.read_negation_count;
    // recovery alone covers a short negation time
    assign neg_long = (neg_cnt > t.strobe_recovery_count);
    assign drive_win = cmd_r.dir_write && in_data_phase(state_nxt);

    always_comb begin
        state_nxt = state_r;
        load      = 1'b0;
        load_val  = CNT_ZERO;
        unique case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = ST_SETUP;
                    load      = 1'b1;
                    load_val  = t.select_setup_count;
                end
            end
            ST_SETUP: begin
                if (expired) begin
                    state_nxt = ST_ACTIVE;
                    load      = 1'b1;
                    load_val  = t.strobe_active_count;
                end
            end
            ST_ACTIVE: begin
                if (expired) begin
                    state_nxt = ST_RECOV;
                    load      = 1'b1;
                    load_val  = t.strobe_recovery_count;
                end
            end
            ST_RECOV: begin
                if (expired) begin
                    load = 1'b1;
                    if (more) begin
                        // negation time beyond recovery, counted from strobe negation
                        state_nxt = neg_long ? ST_NEG : ST_ACTIVE;
                        load_val  = neg_long ? neg_cnt - t.strobe_recovery_count
                                             : t.strobe_active_count;
                    end else begin
                        state_nxt = ST_EOC;
                        load_val  = t.end_of_cycle_extension;
                    end
                end
            end
            ST_NEG: begin
                if (expired) begin
                    state_nxt = ST_ACTIVE;
                    load      = 1'b1;
                    load_val  = t.strobe_active_count;
                end
            end
            ST_EOC: begin
                if (expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers and pins
    // ------------------------------------------------------------
    logic act_end;
    logic act_start;

    assign act_end   = (state_r == ST_ACTIVE) && expired;
    // last cycle before every strobe; its closing edge asserts the strobe
    assign act_start = (state_nxt == ST_ACTIVE) && (state_r != ST_ACTIVE);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= ST_IDLE;
            cmd_r     <= '0;
            left_r    <= LEN_ZERO;
            disk_ctl  <= CTL_IDLE;
            busy      <= 1'b0;
            word_req  <= 1'b0;
            rd_data   <= DATA_RST;
            rd_valid  <= 1'b0;
            disk_data_out <= DATA_RST;
            disk_data_oe  <= 1'b0;
            alternate_disk_data_bus_out <= DATA_RST;
            alternate_disk_data_bus_oe  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            busy     <= (state_nxt != ST_IDLE);
            word_req <= 1'b0;
            rd_valid <= 1'b0;
            if (state_r == ST_IDLE && start_ok) begin
                cmd_r  <= cmd;
                left_r <= cmd.word_count;
            end
            // ack spans setup through end of cycle; selects stay high
            disk_ctl.dma_ack_n <= (state_nxt == ST_IDLE);
            disk_ctl.cs_low_n  <= 1'b1;
            disk_ctl.cs_high_n <= 1'b1;
            disk_ctl.read_strobe_n  <= !((state_nxt == ST_ACTIVE) && !cmd_r.dir_write
                                         && !(state_r == ST_IDLE));
            disk_ctl.write_strobe_n <= !((state_nxt == ST_ACTIVE) && cmd_r.dir_write);
            // count drops as each strobe starts, so more sees the words left
            if (act_start) begin
                left_r <= left_r - LEN_ONE;
                word_req <= cmd_r.dir_write;
                // data stands from strobe assertion through recovery
                if (cmd_r.use_alternate) begin
                    alternate_disk_data_bus_out <= wr_data;
                end else begin
                    disk_data_out <= wr_data;
                end
            end
            disk_data_oe <= drive_win && !cmd_r.use_alternate;
            alternate_disk_data_bus_oe <= drive_win && cmd_r.use_alternate;
            if (act_end && !cmd_r.dir_write) begin
                // sampled data lags pin by the two synchroniser stages
                rd_data  <= din_s2_r;
                rd_valid <= 1'b1;
            end
        end
    end

endmodule : amd_mdma

// ---- src/amd_pkg.sv ----
package amd_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W  = 8;
    localparam int DATA_W = 16;
    localparam int LEN_W  = 16;

    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_ONE  = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // counts in system clock cycles, all at least one
    typedef struct packed {
        logic [CNT_W-1:0] strobe_active_count;
        logic [CNT_W-1:0] strobe_recovery_count;
        logic [CNT_W-1:0] select_setup_count;
        logic [CNT_W-1:0] read_negation_count;
        logic [CNT_W-1:0] write_negation_count;
        logic [CNT_W-1:0] end_of_cycle_extension;
    } amd_timing_t;

    typedef struct packed {
        logic              dir_write;
        logic              use_alternate;
        logic [LEN_W-1:0]  word_count;
    } amd_cmd_t;

    typedef struct packed {
        logic              read_strobe_n;
        logic              write_strobe_n;
        logic              dma_ack_n;
        logic              cs_low_n;
        logic              cs_high_n;
    } amd_ctl_t;

    localparam amd_ctl_t CTL_IDLE = 5'h1F;

endpackage : amd_pkg
